// >>> scs_pkg.sv
package scs_pkg;

    // ==========================================================
    // Clock and time base
    localparam int unsigned CLK_FREQ_HZ  = 200_000_000;
    localparam int unsigned US_PER_S     = 1_000_000;
    // Clock cycles per microsecond tick, never below one
    localparam int unsigned TICK_US_CYC  =
        (CLK_FREQ_HZ / US_PER_S) < 1 ? 1 : (CLK_FREQ_HZ / US_PER_S);
    // Cycle time is kept in tenths of a millisecond
    localparam int unsigned TENTH_MS_US  = 100;

    // ==========================================================
    // Phase durations in microseconds, and the count of init ops
    localparam int unsigned OVERSEE_US      = 3000;
    localparam int unsigned DUPLEX_SYNC_US  = 1000;
    localparam int unsigned IO_CHECK_US     = 800;
    localparam int unsigned OUT_WORD_US     = 18;
    localparam int unsigned RIO_MASTER_US   = 1000;
    localparam int unsigned RIO_WORD_US     = 20;
    localparam int unsigned SLOT_MOUNTED_US = 1500;
    localparam int unsigned SLOT_ABSENT_US  = 500;
    localparam int unsigned IN_WORD_US      = 25;
    localparam int unsigned INIT_OPS        = 3;

    // ==========================================================
    // Cycle time limits
    localparam int unsigned CYC_ERR_MS     = 100;
    localparam int unsigned FATAL_MS       = 6500;
    localparam int unsigned CYC_ERR_TENTHS = CYC_ERR_MS * 1000 / TENTH_MS_US;
    localparam int unsigned FATAL_TENTHS   = FATAL_MS * 1000 / TENTH_MS_US;
    localparam logic [7:0]  FATAL_CODE     = 8'h9F;
    // Bit address at which software sees the cycle time error flag
    localparam int unsigned ERR_FLAG_BIT_ADDR = 25309;

    // ==========================================================
    // Widths and reset values
    localparam int unsigned DUR_W  = 20;
    localparam int unsigned TIME_W = 16;
    localparam logic [15:0] TIME_RST = 16'h0000;

    // Service slots, coded in repeat rotation order
    typedef enum logic [1:0] {
        SLOT_PCL1 = 2'h0,
        SLOT_PCL2 = 2'h1,
        SLOT_PERI = 2'h2,
        SLOT_HOST = 2'h3
    } scs_slot_type;

    typedef enum logic [2:0] {
        ST_INIT    = 3'h0,
        ST_OVERSEE = 3'h1,
        ST_IOCHECK = 3'h2,
        ST_OUTREF  = 3'h3,
        ST_RIO     = 3'h4,
        ST_SLOT    = 3'h5,
        ST_INREF   = 3'h6,
        ST_STOP    = 3'h7
    } scs_state_type;

endpackage : scs_pkg

// >>> scs_tick_if.sv
`timescale 1ns/100ps
// ==========================================================
// Time base ticks shared between the sequencer and divider
interface scs_tick_if;
    logic tick_us;     // One-cycle pulse each microsecond
    logic tick_tenth;  // One-cycle pulse each 0.1 ms
    logic restart;     // Realign both dividers at cycle start

    modport gen (input restart, output tick_us, output tick_tenth);
    modport usr (output restart, input tick_us, input tick_tenth);
endinterface : scs_tick_if

// >>> scs_timebase.sv
`timescale 1ns/100ps
// ==========================================================
// Free-running divider: clock to microseconds to tenths of ms
module scs_timebase
    import scs_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_US_CYC  // Clocks per us tick
) (
    input  wire logic   clk_i,    // 200 MHz clock
    input  wire logic   rst_n_i,  // Async reset, active low
    scs_tick_if.gen     tb        // Tick outputs, restart input
);
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic [6:0] us_q;
    logic [6:0] us_d;
    logic       wrap_us;
    logic       wrap_tenth;

    // Tick decode; restart swallows a coincident tick
    always_comb begin
        wrap_us       = (div_q == 8'(TICK_CYC - 1));
        wrap_tenth    = wrap_us && (us_q == 7'(TENTH_MS_US - 1));
        tb.tick_us    = wrap_us && !tb.restart;
        tb.tick_tenth = wrap_tenth && !tb.restart;
        div_d         = wrap_us ? 8'h00 : div_q + 8'h01;
        us_d          = us_q;
        if (wrap_tenth) begin
            us_d = 7'h00;
        end else if (wrap_us) begin
            us_d = us_q + 7'h01;
        end
        if (tb.restart) begin
            div_d = 8'h00;
            us_d  = 7'h00;
        end
    end

    // Divider registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 8'h00;
            us_q  <= 7'h00;
        end else begin
            div_q <= div_d;
            us_q  <= us_d;
        end
    end

endmodule : scs_timebase

// >>> scs_sequencer.sv
`timescale 1ns/100ps
// Operation
// - After init, loop overseeing, output refresh with servicing, input refresh
// - The three power-up operations run once per power-on only
// - Unit servicing repeats until the program finishes executing
// - Overseeing restarts watchdog, checks cycle; 3.0 ms, plus 1.0 ms duplex
// - Output phase opens with a 0.8 ms I/O and bus check
// - Output refresh costs 18 us per output word
// - Each remote master costs 1 ms plus 20 us per word
// - Each service slot takes 1.5 ms if mounted, 0.5 ms if absent
// - Input refresh costs 25 us per input word
// - Every cycle first services each link unit and peripheral once
// - While program runs, service again one type per slot, no remotes
// - Repeat slots rotate PC link I, II, peripheral, host; resume
// - Program completion tested after the first pass and between repeat slots; servicing ends at once
// - Cycle of 100 ms or more sets the cycle time error flag
// - Cycle of 6,500 ms or more raises code 9F and stops
// - Maximum and current cycle time words kept, updated every cycle
module scs_sequencer
    import scs_pkg::*;
#(
    parameter int unsigned INIT_OP_US = 10,         // Length of each init op
    parameter int unsigned TICK_CYC   = TICK_US_CYC // Clocks per us tick
) (
    input  wire logic         clk_i,          // 200 MHz clock
    input  wire logic         rst_n_i,        // Async reset, active low
    input  wire logic         duplex_i,       // Duplex CPU configuration
    input  wire logic [7:0]   out_words_i,    // Local output words
    input  wire logic [7:0]   in_words_i,     // Local input words
    input  wire logic [2:0]   rio_masters_i,  // Remote I/O masters
    input  wire logic [7:0]   rio_words_i,    // Words per remote master
    input  wire logic [3:0]   unit_mounted_i, // Mounted, by slot code
    input  wire logic         prog_done_i,    // Program finished pulse
    output logic [2:0]        phase_o,        // Current phase code
    output logic [1:0]        slot_o,         // Slot being serviced
    output logic              wdt_restart_o,  // Watchdog restart pulse
    output logic              prog_start_o,   // Program start pulse
    output logic              cycle_err_o,    // Cycle time error flag
    output logic              fatal_stop_o,   // Fatal alarm stop
    output logic [7:0]        fatal_code_o,   // Fatal alarm code
    output logic [TIME_W-1:0] max_cycle_o,    // Max cycle, 0.1 ms units
    output logic [TIME_W-1:0] cur_cycle_o     // Last cycle, 0.1 ms units
);
    // ==========================================================
    // Helpers
    function automatic logic [DUR_W-1:0] words_us(
        input logic [7:0] words,
        input int unsigned per_word
    );
        words_us = DUR_W'(words) * DUR_W'(per_word);
    endfunction : words_us

    function automatic logic [DUR_W-1:0] slot_us(input logic mounted);
        slot_us = mounted ? DUR_W'(SLOT_MOUNTED_US)
                          : DUR_W'(SLOT_ABSENT_US);
    endfunction : slot_us

    // First-pass order: peripheral, host, PC link I, PC link II
    function automatic scs_slot_type first_slot(input logic [1:0] idx);
        unique case (idx)
            2'h0:    first_slot = SLOT_PERI;
            2'h1:    first_slot = SLOT_HOST;
            2'h2:    first_slot = SLOT_PCL1;
            2'h3:    first_slot = SLOT_PCL2;
        endcase
    endfunction : first_slot

    // ==========================================================
    // Time base
    scs_tick_if tick ();

    scs_timebase #(
        .TICK_CYC (TICK_CYC)
    ) u_timebase (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .tb      (tick.gen)
    );

    // ==========================================================
    // Sequencer state
    scs_state_type     state_q, state_d;
    scs_slot_type      slot_q, slot_d;
    scs_slot_type      rot_q, rot_d;
    logic [DUR_W-1:0]  rem_q, rem_d;
    logic [2:0]        mcnt_q, mcnt_d;
    logic [1:0]        fp_q, fp_d;
    logic              first_q, first_d;
    logic              done_q, done_d;
    logic [1:0]        init_q, init_d;
    logic [TIME_W-1:0] cnt_q, cnt_d;
    logic [TIME_W-1:0] cur_q, cur_d;
    logic [TIME_W-1:0] max_q, max_d;
    logic              err_q, err_d;
    logic              enter_ov;
    logic              start_prog;
    logic              fatal_hit;

    // Next-state logic; a phase ends when its remaining time is zero
    always_comb begin
        state_d    = state_q;
        slot_d     = slot_q;
        rot_d      = rot_q;
        mcnt_d     = mcnt_q;
        fp_d       = fp_q;
        first_d    = first_q;
        init_d     = init_q;
        cur_d      = cur_q;
        max_d      = max_q;
        err_d      = err_q;
        enter_ov   = 1'b0;
        start_prog = 1'b0;
        rem_d      = rem_q;
        if (tick.tick_us && rem_q != '0) begin
            rem_d = rem_q - DUR_W'(1);
        end
        // Time base runs only inside the cycle
        cnt_d = cnt_q;
        if (tick.tick_tenth && state_q != ST_INIT && state_q != ST_STOP
            && cnt_q != '1) begin
            cnt_d = cnt_q + TIME_W'(1);
        end
        fatal_hit = (cnt_q >= TIME_W'(FATAL_TENTHS));
        if (state_q != ST_INIT && state_q != ST_STOP && fatal_hit) begin
            state_d = ST_STOP;
        end else if (rem_q == '0) begin
            unique case (state_q)
                ST_INIT: begin
                    if (init_q == 2'(INIT_OPS - 1)) begin
                        enter_ov = 1'b1;
                    end else begin
                        init_d = init_q + 2'h1;
                        rem_d  = DUR_W'(INIT_OP_US);
                    end
                end
                ST_OVERSEE: begin
                    state_d    = ST_IOCHECK;
                    rem_d      = DUR_W'(IO_CHECK_US);
                    start_prog = 1'b1;
                end
                ST_IOCHECK: begin
                    state_d = ST_OUTREF;
                    rem_d   = words_us(out_words_i, OUT_WORD_US);
                end
                ST_OUTREF, ST_RIO: begin
                    // Each master refreshes both directions in turn
                    if ((state_q == ST_OUTREF && rio_masters_i != 3'h0)
                        || (state_q == ST_RIO && mcnt_q > 3'h1)) begin
                        state_d = ST_RIO;
                        mcnt_d  = (state_q == ST_OUTREF)
                                  ? rio_masters_i : mcnt_q - 3'h1;
                        rem_d   = DUR_W'(RIO_MASTER_US)
                                  + words_us(rio_words_i, RIO_WORD_US);
                    end else begin
                        state_d = ST_SLOT;
                        first_d = 1'b1;
                        fp_d    = 2'h0;
                        slot_d  = first_slot(2'h0);
                        rem_d   = slot_us(unit_mounted_i[first_slot(2'h0)]);
                    end
                end
                ST_SLOT: begin
                    if (first_q && fp_q != 2'h3) begin
                        // First pass always completes all four units
                        fp_d   = fp_q + 2'h1;
                        slot_d = first_slot(fp_q + 2'h1);
                        rem_d  = slot_us(unit_mounted_i[slot_d]);
                    end else if (done_q) begin
                        first_d = 1'b0;
                        state_d = ST_INREF;
                        rem_d   = words_us(in_words_i, IN_WORD_US);
                    end else begin
                        // Remote masters never get extra slots
                        first_d = 1'b0;
                        slot_d  = rot_q;
                        rot_d   = scs_slot_type'(rot_q + 2'h1);
                        rem_d   = slot_us(unit_mounted_i[rot_q]);
                    end
                end
                ST_INREF: begin
                    // Close out the cycle measurement
                    cur_d = cnt_q;
                    if (cnt_q > max_q) begin
                        max_d = cnt_q;
                    end
                    err_d    = (cnt_q >= TIME_W'(CYC_ERR_TENTHS));
                    enter_ov = 1'b1;
                end
                ST_STOP: begin
                    state_d = ST_STOP;
                end
            endcase
        end
        if (enter_ov) begin
            state_d = ST_OVERSEE;
            rem_d   = DUR_W'(OVERSEE_US)
                      + (duplex_i ? DUR_W'(DUPLEX_SYNC_US) : '0);
            cnt_d   = '0;
        end
        // A completion arriving with the start pulse is kept
        done_d = prog_done_i || (done_q && !start_prog);
    end

    assign tick.restart = enter_ov;

    // State registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_INIT;
            slot_q  <= SLOT_PERI;
            rot_q   <= SLOT_PCL1;
            rem_q   <= DUR_W'(INIT_OP_US);
            mcnt_q  <= 3'h0;
            fp_q    <= 2'h0;
            first_q <= 1'b0;
            done_q  <= 1'b0;
            init_q  <= 2'h0;
            cnt_q   <= TIME_RST;
            cur_q   <= TIME_RST;
            max_q   <= TIME_RST;
            err_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            slot_q  <= slot_d;
            rot_q   <= rot_d;
            rem_q   <= rem_d;
            mcnt_q  <= mcnt_d;
            fp_q    <= fp_d;
            first_q <= first_d;
            done_q  <= done_d;
            init_q  <= init_d;
            cnt_q   <= cnt_d;
            cur_q   <= cur_d;
            max_q   <= max_d;
            err_q   <= err_d;
        end
    end

    // ==========================================================
    // Outputs
    assign phase_o       = state_q;
    assign slot_o        = slot_q;
    assign wdt_restart_o = enter_ov;
    assign prog_start_o  = start_prog;
    assign cycle_err_o   = err_q;
    assign fatal_stop_o  = (state_q == ST_STOP);
    assign fatal_code_o  = (state_q == ST_STOP) ? FATAL_CODE : 8'h00;
    assign max_cycle_o   = max_q;
    assign cur_cycle_o   = cur_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seq_slot_end;
        state_q == ST_SLOT && rem_q == '0;
    endsequence

    sequence seq_repeat_slot;
        seq_slot_end ##0 (!first_q || fp_q == 2'h3) ##0 !done_q;
    endsequence

    AST_INIT_ONCE: assert property (
        state_q == ST_INIT |-> $past(state_q) == ST_INIT)
        else $error("Init phase reentered");
    AST_PROG_AFTER_OVERSEE: assert property (
        prog_start_o |-> state_q == ST_OVERSEE ##1 state_q == ST_IOCHECK)
        else $error("Program start outside oversee exit");
    AST_NO_EARLY_INREF: assert property (
        state_q == ST_INREF && $past(state_q) == ST_SLOT
        |-> $past(done_q) && ($past(fp_q) == 2'h3 || !$past(first_q)))
        else $error("Servicing ended before program done");
    AST_OVERSEE_TIME: assert property (
        wdt_restart_o |=> rem_q == ($past(duplex_i) ? DUR_W'(4000)
                                                    : DUR_W'(3000)))
        else $error("Oversee time wrong");
    AST_IOCHECK_TIME: assert property (
        $rose(state_q == ST_IOCHECK) |-> rem_q == DUR_W'(800))
        else $error("I/O check time wrong");
    AST_ROTATE: assert property (
        seq_repeat_slot |=> state_q == ST_SLOT
        && slot_q == $past(rot_q) && rot_q == $past(rot_q) + 2'h1)
        else $error("Repeat slot rotation broken");
    AST_DONE_ENDS: assert property (
        seq_slot_end ##0 done_q ##0 (!first_q || fp_q == 2'h3)
        |=> state_q == ST_INREF)
        else $error("Servicing continued after completion");
    AST_ERR_FLAG: assert property (
        state_q == ST_INREF && rem_q == '0 && !fatal_hit
        |=> cycle_err_o == (cur_cycle_o >= TIME_W'(1000)))
        else $error("Cycle error flag wrong");
    AST_FATAL: assert property (
        state_q != ST_INIT && cnt_q >= TIME_W'(65000)
        |=> fatal_stop_o && fatal_code_o == 8'h9F ##1 fatal_stop_o)
        else $error("Fatal stop not raised");
    AST_MAX_CUR: assert property (
        state_q == ST_INREF && rem_q == '0 && !fatal_hit
        |=> cur_cycle_o == $past(cnt_q) && max_cycle_o >= cur_cycle_o)
        else $error("Cycle time words not updated");

endmodule : scs_sequencer

// >>> scs_prog_model.sv
`timescale 1ns/100ps
// ==========================================================
// Program execution: busy for a set time after each start
module scs_prog_model
    import scs_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_US_CYC  // Clocks per us tick
) (
    input  wire logic        clk_i,        // 200 MHz clock
    input  wire logic        rst_n_i,      // Async reset, active low
    input  wire logic        prog_start_i, // Start pulse from sequencer
    input  wire logic [15:0] run_us_i,     // Program run time in us
    output logic             prog_done_o,  // One-cycle done pulse
    output logic             busy_o        // Program still running
);
    int unsigned cnt;

    // Runs beside output refresh; moves only at falling edges
    always @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt = 0;
            prog_done_o = 1'b0;
        end else begin
            prog_done_o = 1'b0;
            if (prog_start_i) begin
                cnt = run_us_i * TICK_CYC;
                prog_done_o = (cnt == 0);
            end else if (cnt > 0) begin
                cnt = cnt - 1;
                prog_done_o = (cnt == 0);
            end
        end
    end
    assign busy_o = (cnt != 0); // Done pulse ends the busy span
endmodule : scs_prog_model

// >>> scan_cycle_scheduler_tb.sv
`timescale 1ns/100ps
module scan_cycle_scheduler_tb
    import scs_pkg::*;
;
    typedef struct {
        logic dup; logic [7:0] ow; logic [7:0] iw; logic [2:0] rm;
        logic [7:0] rw; logic [3:0] mnt; logic [15:0] prog;
        int c1; int c2; logic [31:0] seq;
    } scs_row_type;
    // ==========================================================
    // Signals
    logic               clk_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic               duplex_i, prog_done_i, busy, wdt, ps;
    logic [7:0]         out_words_i, in_words_i, rio_words_i;
    logic [2:0]         rio_masters_i, phase_o, last_ph;
    logic [3:0]         unit_mounted_i;
    logic [15:0]        run_us;
    logic [1:0]         slot_o, last_slot;
    logic               cycle_err_o, fatal_stop_o;
    logic [7:0]         fatal_code_o;
    logic [TIME_W-1:0]  max_cycle_o, cur_cycle_o;
    logic [31:0]        seq, last_seq;
    int dur [8];
    // One clock per us keeps every scenario within a few tens of
    // thousands of clocks; the real divider would need millions
    localparam int TICK_CYC = 1;
    int errors = 0, check_count = 0, ph_clk = 0, cyc = 0;
    int reinit = 0, late = 0, ps_n = 0, ps_last = 0;
    bit left_init = 0;
    // Ordinary configurations; expected tenths for both cycles
    scs_row_type rows [3] = '{
        '{0, 2, 4, 0, 0, 4'h0, 0, 59, 59, 32'h0000_2301},
        '{1, 1, 2, 2, 3, 4'h5, 8000, 114, 129, 32'h0002_3012},
        '{0, 0, 0, 1, 0, 4'hF, 10000, 148, 138, 32'h0002_3012}};

    always #2.5 clk_i = ~clk_i;

    // ==========================================================
    // Design and program model
    scs_sequencer #(.INIT_OP_US(1), .TICK_CYC(TICK_CYC)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .duplex_i(duplex_i),
        .out_words_i(out_words_i), .in_words_i(in_words_i),
        .rio_masters_i(rio_masters_i), .rio_words_i(rio_words_i),
        .unit_mounted_i(unit_mounted_i), .prog_done_i(prog_done_i),
        .phase_o(phase_o), .slot_o(slot_o), .wdt_restart_o(wdt),
        .prog_start_o(ps), .cycle_err_o(cycle_err_o),
        .fatal_stop_o(fatal_stop_o), .fatal_code_o(fatal_code_o),
        .max_cycle_o(max_cycle_o), .cur_cycle_o(cur_cycle_o));
    scs_prog_model #(.TICK_CYC(TICK_CYC)) u_prog (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .prog_start_i(ps),
        .run_us_i(run_us), .prog_done_o(prog_done_i), .busy_o(busy));

    // ==========================================================
    // Phase monitor: lengths, slot order, ordering faults
    always @(negedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 90_000) begin
            errors = errors + 1;
            summarize();
        end
        if (!rst_n_i) begin
            ph_clk = 0;
            left_init = 0;
        end else if (phase_o !== last_ph) begin
            dur[last_ph] = ph_clk;
            ph_clk = 0;
            if (phase_o === 3'h1) begin
                left_init = 1;
                last_seq = seq;
                seq = 0;
                ps_last = ps_n;
                ps_n = 0;
            end
            if (phase_o === 3'h2) begin
                dur[3] = 0;
                dur[4] = 0;
            end
            if (phase_o === 3'h0 && left_init) reinit = reinit + 1;
            if (phase_o === 3'h6 && busy) late = late + 1;
        end
        if (phase_o === 3'h5 && (last_ph !== 3'h5 || slot_o !== last_slot))
            seq = (seq << 4) | slot_o;
        if (ps === 1'b1) ps_n = ps_n + 1;
        ph_clk = ph_clk + 1;
        last_ph = phase_o;
        last_slot = slot_o;
    end

    // ==========================================================
    // Compare tasks
    task automatic chk_near(input logic [31:0] got, input int exp,
                            input int tol);
        check_count = check_count + 1;
        if ($isunknown(got) || int'(got) > exp + tol ||
            int'(got) < exp - tol) begin
            errors = errors + 1;
            $display("[ERR] %0t got %0d expected %0d", $time, got, exp);
        end
    endtask : chk_near

    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_eq

    // Wait for the end of the running cycle, let the words land
    task automatic wait_cyc();
        do @(negedge clk_i); while (wdt !== 1'b1);
        repeat (2) @(negedge clk_i);
    endtask : wait_cyc

    // Reset pulse with a check of the values held in reset
    task automatic do_reset();
        rst_n_i = 1'b0;
        repeat (5) @(negedge clk_i);
        chk_eq({phase_o, slot_o, wdt, ps}, 7'h08);
        chk_eq({cycle_err_o, fatal_stop_o, fatal_code_o}, 10'h0);
        chk_eq({max_cycle_o, cur_cycle_o}, 32'h0);
        rst_n_i = 1'b1;
        wait_cyc();
        chk_near(dur[0], 3 * TICK_CYC, 4);
        $display("reset test done");
    endtask : do_reset

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // ==========================================================
    // Main sequence
    initial begin
        {duplex_i, out_words_i, in_words_i} = {1'b0, 8'd2, 8'd4};
        {rio_masters_i, rio_words_i, unit_mounted_i} = 15'h0;
        run_us = 16'h0;
        last_ph = 3'h0;
        last_slot = 2'h0;
        seq = 0;
        last_seq = 0;
        do_reset();
        foreach (rows[i]) begin
            duplex_i = rows[i].dup;
            out_words_i = rows[i].ow;
            in_words_i = rows[i].iw;
            rio_masters_i = rows[i].rm;
            rio_words_i = rows[i].rw;
            unit_mounted_i = rows[i].mnt;
            run_us = rows[i].prog;
            wait_cyc();
            chk_near(cur_cycle_o, rows[i].c1, 1);
            wait_cyc();
            chk_near(cur_cycle_o, rows[i].c2, 1);
            chk_eq(last_seq, rows[i].seq);
            chk_near(dur[1], (rows[i].dup ? 4000 : 3000) * TICK_CYC, 4);
            chk_near(dur[2], 800 * TICK_CYC, 4);
            chk_near(dur[3], 18 * rows[i].ow * TICK_CYC, 4);
            chk_near(dur[4], rows[i].rm * (1000 + 20 * rows[i].rw)
                     * TICK_CYC, 4);
            chk_near(dur[6], 25 * rows[i].iw * TICK_CYC, 4);
            chk_eq({cycle_err_o, fatal_stop_o, fatal_code_o}, 10'h0);
            chk_eq(ps_last, 1);
            $display("row %0d done", i);
        end
        chk_near(max_cycle_o, 148, 1);
        chk_eq(late, 0);
        chk_eq(reinit, 0);
        // Second reset in mid-cycle clears the words again
        repeat (3000) @(negedge clk_i);
        do_reset();
        summarize();
    end
endmodule : scan_cycle_scheduler_tb
